// ### core/pmcfg_defines.svh
// offsets, reset values, limits and timing for the config block
`ifndef PMCFG_DEFINES_SVH
`define PMCFG_DEFINES_SVH
`define CLK_PERIOD_NS      20
`define MS_TICK_NS         1000000
`define HYST_DEG           9'h00f
`define OFS_THERM_CFG      4'h0
`define OFS_THERM_DELAY    4'h1
`define OFS_TRACK_CFG      4'h2
`define OFS_MARGIN_HIGH    4'h3
`define OFS_MARGIN_LOW     4'h4
`define OFS_MARGIN_CTRL    4'h5
`define OFS_PHASE          4'h6
`define OFS_STATUS         4'h7
`define OFS_FAULT_CLEAR    4'h8
`define RST_TEMP_LIMIT     8'h7d
`define RST_RESPONSE       3'h4
`define RST_RETRY_COUNT    3'h3
`define RST_DELAY_MS       16'h0010
`define NOMINAL_PERMILLE   11'h3e8
`define RST_MARGIN_HIGH    11'h41a
`define RST_MARGIN_LOW     11'h3b6
`define MAX_MARGIN         11'h44c
`define RST_MARGIN_RATE    8'h01
`define RST_MARGIN_OVR     3'h2
`define ADDR_BASE          7'h20
`define ADDR_OPEN          7'h21
`define ADDR_MAX_INDEX     5'h18
`define STRAP_INIT_CYCLES  2'h2
`endif

// ### core/pmcfg_pkg.sv
// types shared by the configuration and fault control block
package pmcfg_pkg;
  typedef enum logic [2:0] {
    RESP_RETRY_FOREVER,
    RESP_RETRY_COUNT,
    RESP_DELAY_SHUTDOWN,
    RESP_RIDE_THROUGH,
    RESP_IMMEDIATE
  } therm_resp_t;
  typedef enum logic [2:0] {
    TS_RUN,
    TS_RUN_DELAY,
    TS_OFF_WAIT,
    TS_OFF_MONITOR,
    TS_OFF_LATCHED
  } therm_state_t;
  typedef enum logic [1:0] {
    STRAP_LOW,
    STRAP_OPEN,
    STRAP_HIGH,
    STRAP_RESISTOR
  } strap_level_t;
  typedef enum logic [1:0] {
    MARGIN_LOW,
    MARGIN_NOMINAL,
    MARGIN_HIGH
  } margin_sel_t;
  typedef struct packed {
    logic enable;
    logic ratio100;
    logic limitByRef;
    logic followAlways;
  } track_cfg_t;
endpackage

// ### core/power_manager_config_fault_ctrl.sv
// thermal fault response, tracking, margining, address and phase control
`timescale 1ns/10ps
`include "pmcfg_defines.svh"
module power_manager_config_fault_ctrl #(
  parameter int MsCycles = `MS_TICK_NS / `CLK_PERIOD_NS
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic [3:0]                address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  output logic      [31:0]               readdata,
  output logic                           waitrequest,
  input  wire logic [7:0]                dieTemp,
  input  wire logic [1:0]                margin_select_pin,
  input  wire logic [1:0]                address_strap_pin,
  input  wire logic [4:0]                addressStrapIndex,
  input  wire logic [2:0]                delay_strap_pin,
  input  wire logic                      trackStrapEnable,
  output logic                           runEnable,
  output logic                           thermalFault,
  output logic                           fault_alert_output,
  output logic      [6:0]                busAddress,
  output logic                           addressReserved,
  output logic      [3:0]                phaseOffset,
  output pmcfg_pkg::track_cfg_t          trackCfg,
  output logic                           softStartUsed,
  output logic      [10:0]               marginTarget,
  output logic      [7:0]                marginRate
);
  logic [1:0]  mgnSync1, mgnSync2;
  logic [1:0]  saSync1, saSync2;
  logic [4:0]  saIdxSync1, saIdxSync2;
  logic [2:0]  dlySync1, dlySync2;
  logic        trkSync1, trkSync2;
  logic [1:0]  initCnt_reg;
  logic [7:0]  tempLimit_reg;
  logic [2:0]  response_reg, retryLimit_reg, marginOvr_reg;
  logic [15:0] delayMs_reg, msCnt_reg, delayCnt_reg;
  logic [4:0]  trackBus_reg, phaseBus_reg;
  logic [10:0] marginHigh_reg, marginLow_reg, clampedWr;
  logic        faultSeen_reg, strapTrack_reg;
  logic [2:0]  strapSs_reg, retryCnt_reg;
  logic        msTick, busWr, overLimit, belowHyst, delayDone;
  logic [1:0]  marginSel;
  pmcfg_pkg::therm_state_t state_reg;
  pmcfg_pkg::therm_state_t state_next;

  // pins come from outside, so two stages before anything reads them
  always_ff @(posedge mclk)
  begin
    mgnSync1   <= margin_select_pin;
    mgnSync2   <= mgnSync1;
    saSync1    <= address_strap_pin;
    saSync2    <= saSync1;
    saIdxSync1 <= addressStrapIndex;
    saIdxSync2 <= saIdxSync1;
    dlySync1   <= delay_strap_pin;
    dlySync2   <= dlySync1;
    trkSync1   <= trackStrapEnable;
    trkSync2   <= trkSync1;
  end

  // one wait state per access; write lands on the edge waitrequest is low
  assign busWr = write && !waitrequest;
  always_ff @(posedge mclk)
  begin
    if (rst)
      waitrequest <= 1'b1;
    else if ((read || write) && waitrequest)
      waitrequest <= 1'b0;
    else
      waitrequest <= 1'b1;
  end

  // writes above nominal plus 10 percent are clamped
  assign clampedWr = (writedata[10:0] > `MAX_MARGIN) ? `MAX_MARGIN
                                                      : writedata[10:0];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tempLimit_reg  <= `RST_TEMP_LIMIT;
      response_reg   <= `RST_RESPONSE;
      retryLimit_reg <= `RST_RETRY_COUNT;
      delayMs_reg    <= `RST_DELAY_MS;
      trackBus_reg   <= 5'h00;
      marginHigh_reg <= `RST_MARGIN_HIGH;
      marginLow_reg  <= `RST_MARGIN_LOW;
      marginOvr_reg  <= `RST_MARGIN_OVR;
      marginRate     <= `RST_MARGIN_RATE;
      phaseBus_reg   <= 5'h00;
    end
    else if (busWr)
    begin
      case (address)
        `OFS_THERM_CFG:
        begin
          tempLimit_reg  <= writedata[7:0];
          response_reg   <= (writedata[10:8] > `RST_RESPONSE) ? `RST_RESPONSE
                                                      : writedata[10:8];
          retryLimit_reg <= writedata[14:12];
        end
        `OFS_THERM_DELAY: delayMs_reg  <= writedata[15:0];
        `OFS_TRACK_CFG:   trackBus_reg <= writedata[4:0];
        `OFS_MARGIN_HIGH: marginHigh_reg <= clampedWr;
        `OFS_MARGIN_LOW:  marginLow_reg  <= clampedWr;
        `OFS_MARGIN_CTRL:
        begin
          marginOvr_reg <= writedata[2:0];
          marginRate    <= writedata[15:8];
        end
        `OFS_PHASE: phaseBus_reg <= {writedata[7:4], writedata[0]};
        default: ;
      endcase
    end
  end

  // straps taken once the sync stages have filled, then frozen
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      initCnt_reg     <= 2'h0;
      busAddress      <= `ADDR_BASE;
      addressReserved <= 1'b0;
      strapTrack_reg  <= 1'b0;
      strapSs_reg     <= 3'h0;
    end
    else if (initCnt_reg != `STRAP_INIT_CYCLES)
      initCnt_reg <= initCnt_reg + 2'h1;
    if (!rst && initCnt_reg == `STRAP_INIT_CYCLES - 2'h1)
    begin
      strapTrack_reg <= trkSync2;
      strapSs_reg    <= dlySync2;
      case (pmcfg_pkg::strap_level_t'(saSync2))
        pmcfg_pkg::STRAP_LOW:  busAddress <= `ADDR_BASE;
        pmcfg_pkg::STRAP_OPEN: busAddress <= `ADDR_OPEN;
        pmcfg_pkg::STRAP_HIGH: addressReserved <= 1'b1;
        default:
          if (saIdxSync2 > `ADDR_MAX_INDEX)
            addressReserved <= 1'b1;
          else
            busAddress <= `ADDR_BASE + {2'h0, saIdxSync2};
      endcase
    end
  end

  // bus setting wins over the strap when its override bit is set
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      trackCfg      <= '0;
      softStartUsed <= 1'b1;
    end
    else if (trackBus_reg[0])
    begin
      trackCfg      <= {trackBus_reg[1], trackBus_reg[2], trackBus_reg[3],
                        trackBus_reg[4]};
      softStartUsed <= !trackBus_reg[1];
    end
    else
    begin
      trackCfg.enable       <= strapTrack_reg;
      trackCfg.ratio100     <= !strapSs_reg[2];
      trackCfg.limitByRef   <= strapSs_reg[1];
      trackCfg.followAlways <= strapSs_reg[0];
      softStartUsed         <= !strapTrack_reg;
    end
  end

  // pin code: 0 low, 1 floating, 2 high
  assign marginSel = marginOvr_reg[0] ? marginOvr_reg[2:1] : mgnSync2;
  always_ff @(posedge mclk)
  begin
    if (rst)
      marginTarget <= `NOMINAL_PERMILLE;
    else
      case (pmcfg_pkg::margin_sel_t'(marginSel))
        pmcfg_pkg::MARGIN_HIGH: marginTarget <= marginHigh_reg;
        pmcfg_pkg::MARGIN_LOW:  marginTarget <= marginLow_reg;
        default:                marginTarget <= `NOMINAL_PERMILLE;
      endcase
  end

  // phase in 22.5 degree steps; 45 degrees per address step
  always_ff @(posedge mclk)
  begin
    if (rst)
      phaseOffset <= 4'h0;
    else if (phaseBus_reg[0])
      phaseOffset <= phaseBus_reg[4:1];
    else
      phaseOffset <= {busAddress[2:0], 1'b0};
  end

  // millisecond enable for the fault delay
  assign msTick = (msCnt_reg == 16'(MsCycles - 1));
  always_ff @(posedge mclk)
  begin
    if (rst || msTick)
      msCnt_reg <= 16'h0000;
    else
      msCnt_reg <= msCnt_reg + 16'h0001;
  end

  assign overLimit = dieTemp > tempLimit_reg;
  assign belowHyst = ({1'b0, dieTemp} + `HYST_DEG) < {1'b0, tempLimit_reg};
  assign delayDone = msTick && (delayCnt_reg >= delayMs_reg);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pmcfg_pkg::TS_RUN:
        if (overLimit)
          case (pmcfg_pkg::therm_resp_t'(response_reg))
            pmcfg_pkg::RESP_RETRY_FOREVER:  state_next = pmcfg_pkg::TS_OFF_WAIT;
            pmcfg_pkg::RESP_RETRY_COUNT:    state_next = pmcfg_pkg::TS_OFF_WAIT;
            pmcfg_pkg::RESP_DELAY_SHUTDOWN: state_next = pmcfg_pkg::TS_RUN_DELAY;
            pmcfg_pkg::RESP_RIDE_THROUGH:   state_next = pmcfg_pkg::TS_RUN;
            default: state_next = pmcfg_pkg::TS_OFF_MONITOR;
          endcase
      pmcfg_pkg::TS_RUN_DELAY:
        if (!overLimit)
          state_next = pmcfg_pkg::TS_RUN;
        else if (delayDone)
          state_next = pmcfg_pkg::TS_OFF_LATCHED;
      pmcfg_pkg::TS_OFF_WAIT:
        if (delayDone && belowHyst)
          state_next = pmcfg_pkg::TS_RUN;
        else if (delayDone && response_reg == 3'(pmcfg_pkg::RESP_RETRY_COUNT)
                 && retryCnt_reg >= retryLimit_reg)
          state_next = pmcfg_pkg::TS_OFF_LATCHED;
      pmcfg_pkg::TS_OFF_MONITOR:
        if (belowHyst)
          state_next = pmcfg_pkg::TS_RUN;
      pmcfg_pkg::TS_OFF_LATCHED:
        if (busWr && address == `OFS_FAULT_CLEAR && writedata[1] && !overLimit)
          state_next = pmcfg_pkg::TS_RUN;
      default: state_next = pmcfg_pkg::TS_RUN;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      state_reg <= pmcfg_pkg::TS_RUN;
    else
      state_reg <= state_next;
  end

  // delay counter restarts whenever the state changes; retry counter clears only in TS_RUN
  always_ff @(posedge mclk)
  begin
    if (rst || state_next != state_reg)
      delayCnt_reg <= 16'h0000;
    else if (delayDone)
      delayCnt_reg <= 16'h0000; // wait again before the next check
    else if (msTick)
      delayCnt_reg <= delayCnt_reg + 16'h0001;
    if (rst || state_reg == pmcfg_pkg::TS_RUN)
      retryCnt_reg <= 3'h0;
    else if (state_reg == pmcfg_pkg::TS_OFF_WAIT && delayDone &&
             retryCnt_reg != 3'h7)
      retryCnt_reg <= retryCnt_reg + 3'h1;
  end

  // sticky alert; a new fault in the clear cycle wins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      faultSeen_reg      <= 1'b0;
      fault_alert_output <= 1'b0;
      thermalFault       <= 1'b0;
      runEnable          <= 1'b0;
    end
    else
    begin
      if (overLimit)
        faultSeen_reg <= 1'b1;
      else if (busWr && address == `OFS_FAULT_CLEAR && writedata[0])
        faultSeen_reg <= 1'b0;
      fault_alert_output <= faultSeen_reg;
      thermalFault       <= overLimit;
      runEnable          <= (state_next == pmcfg_pkg::TS_RUN) ||
                            (state_next == pmcfg_pkg::TS_RUN_DELAY);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      readdata <= 32'h00000000;
    else if (read && waitrequest)
      case (address)
        `OFS_THERM_CFG:   readdata <= {17'h0, retryLimit_reg, 1'b0,
                                       response_reg, tempLimit_reg};
        `OFS_THERM_DELAY: readdata <= {16'h0, delayMs_reg};
        `OFS_TRACK_CFG:   readdata <= {27'h0, trackBus_reg};
        `OFS_MARGIN_HIGH: readdata <= {21'h0, marginHigh_reg};
        `OFS_MARGIN_LOW:  readdata <= {21'h0, marginLow_reg};
        `OFS_MARGIN_CTRL: readdata <= {16'h0, marginRate, 5'h0, marginOvr_reg};
        `OFS_PHASE:       readdata <= {24'h0, phaseBus_reg[4:1], 3'h0,
                                       phaseBus_reg[0]};
        `OFS_STATUS:      readdata <= {2'h0, dieTemp, faultSeen_reg,
                                       addressReserved, busAddress, 3'h0,
                                       phaseOffset, 1'b0, 3'(state_reg),
                                       runEnable, thermalFault};
        default:          readdata <= 32'h00000000;
      endcase
  end
endmodule

// ### verif/pmcfg_sva.sv
// concurrent checks on the configuration and fault control ports
`timescale 1ns/10ps
module pmcfg_sva #(
  parameter int MsCycles = 5
) (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [31:0]           readdata,
  input wire logic                  waitrequest,
  input wire logic                  runEnable,
  input wire logic                  thermalFault,
  input wire logic                  fault_alert_output,
  input wire logic [6:0]            busAddress,
  input wire logic                  addressReserved,
  input wire pmcfg_pkg::track_cfg_t trackCfg,
  input wire logic                  softStartUsed,
  input wire logic [10:0]           marginTarget
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_taken;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  property p_answer;
    s_taken |=> s_answer;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not a one-cycle pulse");
  property p_idle;
    !(read || write) && waitrequest |=> waitrequest;
  endproperty
  a_idle: assert property (p_idle)
    else $error("bus answered with no request");
  property p_rd_hold;
    !(read && waitrequest) |=> $stable(readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_alert;
    $rose(thermalFault) |-> ##[0:2] fault_alert_output;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert missing after thermal fault");
  property p_addr;
    !addressReserved |-> busAddress >= 7'h20 && busAddress <= 7'h38;
  endproperty
  a_addr: assert property (p_addr)
    else $error("bus address out of decoded range");
  property p_margin;
    marginTarget <= 11'h44c;
  endproperty
  a_margin: assert property (p_margin)
    else $error("margin target above ceiling");
  property p_track;
    trackCfg.enable [*2] |-> !softStartUsed;
  endproperty
  a_track: assert property (p_track)
    else $error("soft start used while tracking");
  property p_run_start;
    $fell(rst) |-> ##[0:1] runEnable;
  endproperty
  a_run_start: assert property (p_run_start)
    else $error("output not enabled after reset");
endmodule

bind power_manager_config_fault_ctrl pmcfg_sva #(.MsCycles(MsCycles))
  pmcfg_sva_inst (.mclk(mclk), .rst(rst), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .runEnable(runEnable),
  .thermalFault(thermalFault), .fault_alert_output(fault_alert_output),
  .busAddress(busAddress), .addressReserved(addressReserved),
  .trackCfg(trackCfg), .softStartUsed(softStartUsed),
  .marginTarget(marginTarget));

// ### verif/strap_board.sv
// board model: address, soft-start and tracking straps and margin pin
`timescale 1ns/10ps
module strap_board (
  input  wire logic [1:0] addrMode,
  input  wire logic [4:0] addrIdx,
  input  wire logic [2:0] ssRow,
  input  wire logic       trkEn,
  input  wire logic [1:0] mgnLevel,
  output logic      [1:0] address_strap_pin,
  output logic      [4:0] addressStrapIndex,
  output logic      [2:0] delay_strap_pin,
  output logic            trackStrapEnable,
  output logic      [1:0] margin_select_pin
);
  // no resistor fitted: the index reader sees an open input, all ones
  assign address_strap_pin = addrMode;
  assign addressStrapIndex = (addrMode == 2'h3) ? addrIdx : 5'h1f;
  assign delay_strap_pin   = ssRow;
  assign trackStrapEnable  = trkEn;
  assign margin_select_pin = mgnLevel;
endmodule

// ### verif/tb_top.sv
// self-checking bench for the configuration and fault control block
`timescale 1ns/10ps
module tb_top;
  logic                  mclk = 1'b0;
  logic                  rst = 1'b1;
  logic [3:0]            address = 4'h0;
  logic                  read = 1'b0;
  logic                  write = 1'b0;
  logic [31:0]           writedata = 32'h0;
  logic [7:0]            dieTemp = 8'h19;
  logic [1:0]            addrMode = 2'h0;
  logic [4:0]            addrIdx = 5'h0;
  logic [2:0]            ssRow = 3'h0;
  logic                  trkEn = 1'b0;
  logic [1:0]            mgnLevel = 2'h1;
  logic [31:0]           readdata, q;
  logic [1:0]            mgnPin, addrPin;
  logic [4:0]            idxPin;
  logic [2:0]            dlyPin;
  logic                  waitrequest, trkPin, runEnable, thermalFault;
  logic                  alert, addrRes, ssUsed;
  logic [6:0]            busAddress;
  logic [3:0]            phaseOffset;
  pmcfg_pkg::track_cfg_t trackCfg;
  logic [10:0]           marginTarget;
  logic [7:0]            marginRate;
  int                    err_total = 0;
  int                    n_checks = 0;
  int                    cyc = 0;

  always #10 mclk = ~mclk;

  // short ms tick keeps the thermal delays to a few dozen cycles
  power_manager_config_fault_ctrl #(.MsCycles(5))
    power_manager_config_fault_ctrl_inst (.mclk(mclk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .dieTemp(dieTemp),
    .margin_select_pin(mgnPin), .address_strap_pin(addrPin),
    .addressStrapIndex(idxPin), .delay_strap_pin(dlyPin),
    .trackStrapEnable(trkPin), .runEnable(runEnable),
    .thermalFault(thermalFault), .fault_alert_output(alert),
    .busAddress(busAddress), .addressReserved(addrRes),
    .phaseOffset(phaseOffset), .trackCfg(trackCfg),
    .softStartUsed(ssUsed), .marginTarget(marginTarget),
    .marginRate(marginRate));

  strap_board strap_board_inst (.addrMode(addrMode), .addrIdx(addrIdx),
    .ssRow(ssRow), .trkEn(trkEn), .mgnLevel(mgnLevel),
    .address_strap_pin(addrPin), .addressStrapIndex(idxPin),
    .delay_strap_pin(dlyPin), .trackStrapEnable(trkPin),
    .margin_select_pin(mgnPin));

  task automatic close_out;
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // straps are only captured after reset, so each setup needs a restart
  task automatic restart;
    rst <= 1'b1;
    tick(4);
    rst <= 1'b0;
    tick(6);
  endtask

  task automatic xfer(input logic we, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
    @(posedge mclk);
    read <= !we;
    write <= we;
    address <= a;
    writedata <= d;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic t_regs;
    xfer(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h347d);
    xfer(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'h0);
    xfer(1'b0, 4'h9, 32'h0, q);
    chk(q, 32'h0);
    xfer(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h3b6);
    xfer(1'b1, 4'h3, 32'h4b0, q);
    xfer(1'b0, 4'h3, 32'h0, q);
    chk(q, 32'h44c);
    xfer(1'b1, 4'h4, 32'h0, q);
  endtask

  task automatic t_margin;
    mgnLevel <= 2'h2;
    tick(5);
    chk({21'h0, marginTarget}, 32'h44c);
    mgnLevel <= 2'h1;
    tick(5);
    chk({21'h0, marginTarget}, 32'h3e8);
    mgnLevel <= 2'h0;
    tick(5);
    chk({21'h0, marginTarget}, 32'h0);
    xfer(1'b1, 4'h5, 32'h0705, q);
    tick(3);
    chk({21'h0, marginTarget}, 32'h44c);
    chk({24'h0, marginRate}, 32'h7);
  endtask

  task automatic t_phase;
    xfer(1'b1, 4'h6, 32'hf1, q);
    tick(3);
    chk({28'h0, phaseOffset}, 32'hf);
  endtask

  task automatic t_therm_imm;
    dieTemp <= 8'h7e;
    tick(5);
    chk({30'h0, thermalFault, runEnable}, 32'h2);
    chk({31'h0, alert}, 32'h1);
    dieTemp <= 8'h6f;
    tick(20);
    chk({31'h0, runEnable}, 32'h0);
    dieTemp <= 8'h6d;
    tick(20);
    chk({31'h0, runEnable}, 32'h1);
    xfer(1'b1, 4'h0, 32'h3464, q);
    dieTemp <= 8'h65;
    tick(3);
    chk({31'h0, thermalFault}, 32'h1);
    dieTemp <= 8'h64;
    tick(3);
    chk({31'h0, thermalFault}, 32'h0);
    dieTemp <= 8'h19;
    restart();
  endtask

  task automatic t_therm_delay;
    xfer(1'b1, 4'h1, 32'h1, q);
    xfer(1'b1, 4'h0, 32'h327d, q);
    dieTemp <= 8'h7e;
    tick(4);
    chk({31'h0, runEnable}, 32'h1);
    tick(40);
    chk({31'h0, runEnable}, 32'h0);
    dieTemp <= 8'h19;
    tick(40);
    chk({31'h0, runEnable}, 32'h0);
    xfer(1'b1, 4'h8, 32'h3, q);
    tick(5);
    chk({31'h0, runEnable, alert}, 32'h2);
    xfer(1'b1, 4'h0, 32'h307d, q);
    dieTemp <= 8'h7e;
    tick(6);
    chk({31'h0, runEnable}, 32'h0);
    dieTemp <= 8'h19;
    tick(40);
    chk({31'h0, runEnable}, 32'h1);
    xfer(1'b1, 4'h0, 32'h337d, q);
    dieTemp <= 8'h7e;
    tick(20);
    chk({31'h0, runEnable}, 32'h1);
    xfer(1'b1, 4'h0, 32'h117d, q);
    tick(60);
    dieTemp <= 8'h19;
    tick(40);
    chk({31'h0, runEnable}, 32'h0);
    xfer(1'b0, 4'h7, 32'h0, q);
    chk({29'h0, q[4:2]}, 32'h4);
    xfer(1'b1, 4'h8, 32'h2, q);
    tick(3);
    chk({31'h0, runEnable}, 32'h1);
  endtask

  task automatic t_straps;
    logic [1:0] md [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
    logic [4:0] ix [6] = '{5'h0, 5'h0, 5'h0, 5'h5, 5'h18, 5'h19};
    logic [7:0] ea [6] = '{8'h20, 8'h21, 8'h0, 8'h25, 8'h38, 8'h0};
    for (int i = 0; i < 6; i++)
    begin
      addrMode <= md[i];
      addrIdx <= ix[i];
      restart();
      chk({31'h0, addrRes}, {31'h0, ea[i] == 8'h0});
      if (ea[i] != 8'h0)
      begin
        chk({25'h0, busAddress}, {24'h0, ea[i]});
        chk({28'h0, phaseOffset}, {28'h0, ea[i][2:0], 1'b0});
      end
    end
  endtask

  task automatic t_track;
    trkEn <= 1'b1;
    for (int r = 0; r < 8; r++)
    begin
      ssRow <= r[2:0];
      restart();
      chk({28'h0, trackCfg}, {28'h0, 1'b1, r < 4, r[1], r[0]});
      chk({31'h0, ssUsed}, 32'h0);
    end
    trkEn <= 1'b0;
    restart();
    chk({30'h0, trackCfg.enable, ssUsed}, 32'h1);
    xfer(1'b1, 4'h2, 32'h0b, q);
    tick(3);
    chk({28'h0, trackCfg}, 32'ha);
    chk({31'h0, ssUsed}, 32'h0);
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_total++;
      close_out();
    end
  end

  initial
  begin
    restart();
    t_regs();
    t_margin();
    t_phase();
    t_therm_imm();
    t_therm_delay();
    t_straps();
    t_track();
    close_out();
  end
endmodule
